// ===== core/lpcd_regs_map.svh
`ifndef LPCD_REGS_MAP_SVH
`define LPCD_REGS_MAP_SVH

// ************************************************************
// register offsets
// ************************************************************
`define OFS_PAGE_KEY 8'h37
`define OFS_DET_CTRL 8'h3C
`define OFS_WAKE 8'h3D
`define OFS_WINDOW 8'h3E
`define OFS_SPECIAL 8'h3F
`define OFS_ANALOG 8'h31
`define OFS_NOISE 8'h32
`define OFS_EDGE 8'h33
`define OFS_AGC 8'h34
`define OFS_RXA6 8'h38
`define OFS_RXA7 8'h39
`define OFS_RXA8 8'h3A
`define OFS_RXA9 8'h3B
`define OFS_REF 8'h31
`define OFS_MEAS 8'h32
`define OFS_CAL 8'h33
`define OFS_FTRIM 8'h34
`define OFS_STRIM 8'h35
`define OFS_ADCREF 8'h36
`define OFS_NEGD 8'h38
`define OFS_POSD 8'h39

// ************************************************************
// page keys
// ************************************************************
`define KEY_PAGE4 8'h5E
`define KEY_PAGE5 8'hAE
`define KEY_PAGE6 8'h5A

// ************************************************************
// reset values and writable masks
// ************************************************************
`define RST_PAGE_KEY 8'h15
`define RST_DET_CTRL 8'h00
`define RST_WAKE 8'h0F
`define RST_WINDOW 8'h04
`define RST_SPECIAL 8'h50
`define RST_ANALOG 8'h14
`define RST_NOISE 8'h7D
`define RST_EDGE 8'h00
`define RST_AGC 8'h10
`define RST_RXA6 8'h76
`define RST_RXA7 8'h56
`define RST_RXA8 8'h31
`define RST_RXA9 8'h12
`define RST_CAL 8'h00
`define RST_FTRIM 8'h80
`define RST_STRIM 8'h20
`define RST_ADCREF 8'h80
`define RST_NEGD 8'h30
`define RST_POSD 8'h1F
`define MSK_ALL 8'hFF
`define MSK_DET_CTRL 8'h3F
`define MSK_ANALOG 8'h3E
`define MSK_EDGE 8'h0C
`define MSK_AGC 8'h3F
`define MSK_STRIM 8'h3F
`define MSK_NEGD 8'hF0
`define MSK_POSD 8'h3F

// ************************************************************
// field positions
// ************************************************************
`define BIT_DET_EN 7
`define BIT_CAL_EN 4
`define BIT_CAL_MODE 5
`define BIT_RESYNC 4
`define BIT_FLT_BYP 7
`define BIT_SUBEND 3
`define BIT_NEG_STEP 3
`define BIT_POS_STEP 2
`define BIT_RX_UNIT 1
`define BIT_TX_UNIT 0
`define FLD_DELTA 3:0
`define FLD_SKIP 6:4
`define FLD_WINDOW 3:0
`define FLD_ZERO_HALF 4:2
`define FLD_NEG_DRV 7:4
`define FLD_POS_DRV 5:0
`define FLD_CAL_STEP 7:6

// ************************************************************
// timing
// ************************************************************
`define SYS_CLK_KHZ 40000
`define SLOW_CLK_KHZ 32
`define FAST_CLK_KHZ 27120
`define CARRIER_KHZ 13560
`define WAKE_SCALE 256
`define WINDOW_SCALE (16 * 4)
`define ETU_LONG 128
`define ETU_SHORT 64
`define CAL_MIN 2
`define CAL_MAX 62
`define CAL_SPAN_LO 8
`define CAL_SPAN_HI 7
`define POS_CODE_MAX 63

`endif

// ===== core/lpcd_pkg.sv
package lpcd_pkg;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b000,
		SEQ_SLEEP = 3'b001,
		SEQ_DETECT = 3'b010,
		SEQ_HALT = 3'b011
	} seq_state_t;

	typedef enum logic [1:0] {
		PAGE_NONE = 2'b00,
		PAGE_FOUR = 2'b01,
		PAGE_FIVE = 2'b10,
		PAGE_SIX = 2'b11
	} page_t;

	typedef struct packed {
		logic pskCharResync;
		logic topRateFilterBypass;
		logic subcarrierEndCheckOff;
		logic [2:0] zeroHalfBitThreshold;
	} demod_cfg_t;

	typedef struct packed {
		logic negEdgeStep;
		logic posEdgeStep;
		logic [3:0] negDriveConductance;
		logic [5:0] posDriveConductance;
	} drive_cfg_t;

endpackage

// ===== core/rate_tick.sv
`timescale 1ns/10ps
module rate_tick #(
	parameter int unsigned RATE_KHZ = 32,
	parameter int unsigned SYS_KHZ = 40000
) (
	input wire logic clk,
	input wire logic reset_n,
	output logic tick
);
	logic [16:0] acc_reg;
	logic [16:0] sum;

	// fractional accumulator: one pulse per period of the slower rate
	assign sum = acc_reg + 17'(RATE_KHZ);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			acc_reg <= 17'h00000;
			tick <= 1'h0;
		end else if (sum >= 17'(SYS_KHZ)) begin
			acc_reg <= sum - 17'(SYS_KHZ);
			tick <= 1'h1;
		end else begin
			acc_reg <= sum;
			tick <= 1'h0;
		end
	end
endmodule

// ===== core/guard_timer.sv
`timescale 1ns/10ps
`include "lpcd_regs_map.svh"
module guard_timer #(
	parameter int TIME_W = 6
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic carrierTick,
	input wire logic start,
	input wire logic unitShort,
	input wire logic [TIME_W-1:0] guardTime,
	output logic busy,
	output logic done
);
	logic [TIME_W-1:0] units_reg;
	logic [7:0] cycle_reg;
	logic [7:0] unitLen;

	assign unitLen = unitShort ? 8'(`ETU_SHORT) : 8'(`ETU_LONG);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			units_reg <= '0;
			cycle_reg <= 8'h00;
			busy <= 1'h0;
			done <= 1'h0;
		end else begin
			done <= 1'h0;
			if (start) begin
				units_reg <= guardTime;
				cycle_reg <= 8'h00;
				busy <= 1'h1;
			end else if (busy) begin
				if (units_reg == '0) begin
					busy <= 1'h0;
					done <= 1'h1;
				end else if (carrierTick) begin
					if (cycle_reg == unitLen - 8'h01) begin
						cycle_reg <= 8'h00;
						units_reg <= units_reg - 1'h1;
					end else begin
						cycle_reg <= cycle_reg + 8'h01;
					end
				end
			end
		end
	end
endmodule

// ===== core/lpcd_card_regs.sv
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`include "lpcd_regs_map.svh"
// Overview of operation
// - sleep lasts wake interval times 256 slow clock periods.
// - detection window lasts count times 16 times 4 fast clock periods.
// - card detection runs only while window-control bit 7 is one.
// - tag interrupt raised once successive detections exceed the debounce count.
// - receive guard unit is 128 carrier cycles, or 64 when selected.
// - transmit guard unit is 128 carrier cycles, or 64 when selected.
// - resync bit makes demodulator resync after each phase-keyed character.
// - bit 7 of receive algorithm six bypasses the top-rate filter.
// - bit 3 of receive algorithm six disables subcarrier end check.
// - calibration takes raw sample, or steers positive drive toward converter reference.
// - calibration happens only when detect-control bit 4 is one.
// - latest measurement is readable in page six detected-value register.
// - card present when measurement departs from reference by more than delta.
// - during detection negative driver uses code from bits 7 to 4.
// - during detection positive driver starts from six-bit code in bits 5 to 0, which steering calibration steps.
// - edge-step bits 3 and 2 select stepped negative and positive edges.
// - bits 4 to 2 give zero half-bit threshold for start bit.
// - fast RC oscillator trimmed by calibration value, reset mid-scale.
module lpcd_card_regs (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	input wire logic [7:0] adcSample,
	input wire logic [3:0] normNegDrive,
	input wire logic [5:0] normPosDrive,
	input wire logic rxGuardStart,
	input wire logic [5:0] rxGuardTime,
	output logic rxGuardBusy,
	output logic rxGuardDone,
	input wire logic txGuardStart,
	input wire logic [4:0] txGuardTime,
	output logic txGuardBusy,
	output logic txGuardDone,
	output lpcd_pkg::demod_cfg_t demodCfg,
	output lpcd_pkg::drive_cfg_t driveCfg,
	output logic [7:0] fastRcTrim,
	output logic [5:0] slowRcTrim,
	output logic detectActive,
	output logic measureActive,
	output logic tagDetectIrq
);
	import lpcd_pkg::*;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic page_t pageOf(input logic [7:0] key);
		page_t p;
		p = PAGE_NONE;
		if (key == `KEY_PAGE4) p = PAGE_FOUR;
		if (key == `KEY_PAGE5) p = PAGE_FIVE;
		if (key == `KEY_PAGE6) p = PAGE_SIX;
		return p;
	endfunction

	function automatic logic [7:0] absDiff(input logic [7:0] a, input logic [7:0] b);
		return (a >= b) ? (a - b) : (b - a);
	endfunction

	function automatic logic [5:0] calLimit(input logic [5:0] base, input logic [1:0] sel,
		input logic upper);
		logic [8:0] st;
		logic [8:0] v;
		st = 9'(sel) + 9'h001;
		if (sel == 2'h3) begin
			v = upper ? 9'(`CAL_MAX) : 9'(`CAL_MIN);
		end else if (upper) begin
			v = 9'(base) + st * 9'(`CAL_SPAN_HI);
		end else if (9'(base) >= st * 9'(`CAL_SPAN_LO)) begin
			v = 9'(base) - st * 9'(`CAL_SPAN_LO);
		end else begin
			v = 9'h000;
		end
		if (v > 9'(`POS_CODE_MAX)) v = 9'(`POS_CODE_MAX);
		return v[5:0];
	endfunction

	// ************************************************************
	// page selection
	// ************************************************************
	logic [7:0] pageKey_reg;
	page_t page;
	logic wrKey;
	logic wr4;
	logic wr5;
	logic wr6;

	assign page = pageOf(pageKey_reg);
	assign wrKey = regWr && (regAddr == `OFS_PAGE_KEY);
	assign wr4 = regWr && !wrKey && (page == PAGE_FOUR);
	assign wr5 = regWr && !wrKey && (page == PAGE_FIVE);
	assign wr6 = regWr && !wrKey && (page == PAGE_SIX);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pageKey_reg <= `RST_PAGE_KEY;
		end else if (wrKey) begin
			pageKey_reg <= regWdata;
		end
	end

	// ************************************************************
	// page four registers
	// ************************************************************
	logic [7:0] detCtrl_reg;
	logic [7:0] wake_reg;
	logic [7:0] window_reg;
	logic [7:0] special_reg;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			detCtrl_reg <= `RST_DET_CTRL;
			wake_reg <= `RST_WAKE;
			window_reg <= `RST_WINDOW;
			special_reg <= `RST_SPECIAL;
		end else if (wr4) begin
			case (regAddr)
				`OFS_DET_CTRL: detCtrl_reg <= regWdata & `MSK_DET_CTRL;
				`OFS_WAKE: wake_reg <= regWdata;
				`OFS_WINDOW: window_reg <= regWdata;
				`OFS_SPECIAL: special_reg <= regWdata;
				default: ;
			endcase
		end
	end

	// ************************************************************
	// page five registers
	// ************************************************************
	logic [7:0] analog_reg;
	logic [7:0] noise_reg;
	logic [7:0] edge_reg;
	logic [7:0] agc_reg;
	logic [7:0] rxa6_reg;
	logic [7:0] rxa7_reg;
	logic [7:0] rxa8_reg;
	logic [7:0] rxa9_reg;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			analog_reg <= `RST_ANALOG;
			noise_reg <= `RST_NOISE;
			edge_reg <= `RST_EDGE;
			agc_reg <= `RST_AGC;
			rxa6_reg <= `RST_RXA6;
			rxa7_reg <= `RST_RXA7;
			rxa8_reg <= `RST_RXA8;
			rxa9_reg <= `RST_RXA9;
		end else if (wr5) begin
			case (regAddr)
				`OFS_ANALOG: analog_reg <= regWdata & `MSK_ANALOG;
				`OFS_NOISE: noise_reg <= regWdata;
				`OFS_EDGE: edge_reg <= regWdata & `MSK_EDGE;
				`OFS_AGC: agc_reg <= regWdata & `MSK_AGC;
				`OFS_RXA6: rxa6_reg <= regWdata;
				`OFS_RXA7: rxa7_reg <= regWdata;
				`OFS_RXA8: rxa8_reg <= regWdata;
				`OFS_RXA9: rxa9_reg <= regWdata;
				default: ;
			endcase
		end
	end

	// ************************************************************
	// page six registers
	// ************************************************************
	logic [7:0] cal_reg;
	logic [7:0] fastTrim_reg;
	logic [7:0] slowTrim_reg;
	logic [7:0] adcRef_reg;
	logic [7:0] negDrv_reg;
	logic [7:0] posDrv_reg;
	logic [7:0] ref_reg;
	logic [7:0] meas_reg;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cal_reg <= `RST_CAL;
			fastTrim_reg <= `RST_FTRIM;
			slowTrim_reg <= `RST_STRIM;
			adcRef_reg <= `RST_ADCREF;
			negDrv_reg <= `RST_NEGD;
			posDrv_reg <= `RST_POSD;
		end else if (wr6) begin
			case (regAddr)
				`OFS_CAL: cal_reg <= regWdata;
				`OFS_FTRIM: fastTrim_reg <= regWdata;
				`OFS_STRIM: slowTrim_reg <= regWdata & `MSK_STRIM;
				`OFS_ADCREF: adcRef_reg <= regWdata;
				`OFS_NEGD: negDrv_reg <= regWdata & `MSK_NEGD;
				`OFS_POSD: posDrv_reg <= regWdata & `MSK_POSD;
				default: ;
			endcase
		end
	end

	// ************************************************************
	// read port
	// ************************************************************
	logic [7:0] rdNext;

	always_comb begin
		rdNext = 8'h00;
		if (regAddr == `OFS_PAGE_KEY) begin
			rdNext = pageKey_reg;
		end else begin
			unique case (page)
				PAGE_FOUR: begin
					case (regAddr)
						`OFS_DET_CTRL: rdNext = detCtrl_reg;
						`OFS_WAKE: rdNext = wake_reg;
						`OFS_WINDOW: rdNext = window_reg;
						`OFS_SPECIAL: rdNext = special_reg;
						default: rdNext = 8'h00;
					endcase
				end
				PAGE_FIVE: begin
					case (regAddr)
						`OFS_ANALOG: rdNext = analog_reg;
						`OFS_NOISE: rdNext = noise_reg;
						`OFS_EDGE: rdNext = edge_reg;
						`OFS_AGC: rdNext = agc_reg;
						`OFS_RXA6: rdNext = rxa6_reg;
						`OFS_RXA7: rdNext = rxa7_reg;
						`OFS_RXA8: rdNext = rxa8_reg;
						`OFS_RXA9: rdNext = rxa9_reg;
						default: rdNext = 8'h00;
					endcase
				end
				PAGE_SIX: begin
					case (regAddr)
						`OFS_REF: rdNext = ref_reg;
						`OFS_MEAS: rdNext = meas_reg;
						`OFS_CAL: rdNext = cal_reg;
						`OFS_FTRIM: rdNext = fastTrim_reg;
						`OFS_STRIM: rdNext = slowTrim_reg;
						`OFS_ADCREF: rdNext = adcRef_reg;
						`OFS_NEGD: rdNext = negDrv_reg;
						`OFS_POSD: rdNext = posDrv_reg;
						default: rdNext = 8'h00;
					endcase
				end
				PAGE_NONE: rdNext = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			regRdata <= 8'h00;
		end else begin
			regRdata <= regRd ? rdNext : 8'h00;
		end
	end

	// ************************************************************
	// rate ticks and converter sample capture
	// ************************************************************
	logic slowTick;
	logic fastTick;
	logic carrierTick;
	logic [7:0] adcS1_reg;
	logic [7:0] adcS2_reg;
	logic [7:0] adcS3_reg;
	logic [7:0] adc_reg;

	rate_tick #(.RATE_KHZ(`SLOW_CLK_KHZ), .SYS_KHZ(`SYS_CLK_KHZ)) slowRate (
		.clk(clk), .reset_n(reset_n), .tick(slowTick));
	rate_tick #(.RATE_KHZ(`FAST_CLK_KHZ), .SYS_KHZ(`SYS_CLK_KHZ)) fastRate (
		.clk(clk), .reset_n(reset_n), .tick(fastTick));
	rate_tick #(.RATE_KHZ(`CARRIER_KHZ), .SYS_KHZ(`SYS_CLK_KHZ)) carrierRate (
		.clk(clk), .reset_n(reset_n), .tick(carrierTick));

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			adcS1_reg <= 8'h00;
			adcS2_reg <= 8'h00;
			adcS3_reg <= 8'h00;
			adc_reg <= 8'h00;
		end else begin
			adcS1_reg <= adcSample;
			adcS2_reg <= adcS1_reg;
			adcS3_reg <= adcS2_reg;
			if (adcS2_reg == adcS3_reg) adc_reg <= adcS3_reg;
		end
	end

	// ************************************************************
	// card detection sequencer
	// ************************************************************
	seq_state_t state_reg;
	logic [15:0] sleepCnt_reg;
	logic [9:0] windowCnt_reg;
	logic [3:0] hits_reg;
	logic [5:0] posCode_reg;
	logic calPending_reg;
	logic detEn;
	logic [15:0] sleepTarget;
	logic [9:0] windowTarget;
	logic [5:0] calStep;
	logic [5:0] calLo;
	logic [5:0] calHi;
	logic [6:0] upCode;
	logic present;

	assign detEn = window_reg[`BIT_DET_EN];
	assign sleepTarget = 16'(wake_reg) * 16'(`WAKE_SCALE);
	assign windowTarget = 10'(window_reg[`FLD_WINDOW]) * 10'(`WINDOW_SCALE);
	assign calStep = 6'(cal_reg[`FLD_CAL_STEP]) + 6'h01;
	assign calLo = calLimit(posDrv_reg[`FLD_POS_DRV], cal_reg[`FLD_CAL_STEP], 1'h0);
	assign calHi = calLimit(posDrv_reg[`FLD_POS_DRV], cal_reg[`FLD_CAL_STEP], 1'h1);
	assign upCode = 7'(posCode_reg) + 7'(calStep);
	assign present = absDiff(adc_reg, ref_reg) > 8'(detCtrl_reg[`FLD_DELTA]);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_reg <= SEQ_IDLE;
			sleepCnt_reg <= 16'h0000;
			windowCnt_reg <= 10'h000;
			hits_reg <= 4'h0;
			posCode_reg <= 6'h00;
			calPending_reg <= 1'h0;
			ref_reg <= 8'h00;
			meas_reg <= 8'h00;
			tagDetectIrq <= 1'h0;
		end else if (!detEn) begin
			state_reg <= SEQ_IDLE;
			tagDetectIrq <= 1'h0;
		end else begin
			unique case (state_reg)
				SEQ_IDLE: begin
					posCode_reg <= posDrv_reg[`FLD_POS_DRV];
					calPending_reg <= detCtrl_reg[`BIT_CAL_EN];
					hits_reg <= 4'h0;
					windowCnt_reg <= 10'h000;
					state_reg <= SEQ_DETECT;
				end
				SEQ_SLEEP: begin
					if (sleepCnt_reg >= sleepTarget) begin
						windowCnt_reg <= 10'h000;
						state_reg <= SEQ_DETECT;
					end else if (slowTick) begin
						sleepCnt_reg <= sleepCnt_reg + 16'h0001;
					end
				end
				SEQ_DETECT: begin
					if (windowCnt_reg < windowTarget) begin
						if (fastTick) windowCnt_reg <= windowCnt_reg + 10'h001;
					end else begin
						meas_reg <= adc_reg;
						sleepCnt_reg <= 16'h0000;
						windowCnt_reg <= 10'h000;
						if (calPending_reg && !cal_reg[`BIT_CAL_MODE]) begin
							ref_reg <= adc_reg;
							calPending_reg <= 1'h0;
							state_reg <= SEQ_SLEEP;
						end else if (calPending_reg) begin
							if (absDiff(adc_reg, adcRef_reg) <= 8'(calStep)) begin
								ref_reg <= adc_reg;
								calPending_reg <= 1'h0;
								state_reg <= SEQ_SLEEP;
							end else if (adc_reg < adcRef_reg && upCode <= 7'(calHi)) begin
								posCode_reg <= upCode[5:0];
							end else if (adc_reg > adcRef_reg &&
								7'(posCode_reg) >= 7'(calLo) + 7'(calStep)) begin
								posCode_reg <= posCode_reg - calStep;
							end else begin
								ref_reg <= adc_reg;
								calPending_reg <= 1'h0;
								state_reg <= SEQ_SLEEP;
							end
						end else if (present) begin
							if (hits_reg + 4'h1 > 4'(detCtrl_reg[`FLD_SKIP] & 3'h0) +
								4'(window_reg[`FLD_SKIP])) begin
								tagDetectIrq <= 1'h1;
								state_reg <= SEQ_HALT;
							end else begin
								hits_reg <= hits_reg + 4'h1;
								state_reg <= SEQ_SLEEP;
							end
						end else begin
							hits_reg <= 4'h0;
							state_reg <= SEQ_SLEEP;
						end
					end
				end
				SEQ_HALT: state_reg <= SEQ_HALT;
				default: state_reg <= SEQ_IDLE;
			endcase
		end
	end

	// ************************************************************
	// guard timers
	// ************************************************************
	guard_timer #(.TIME_W(6)) rxGuard (
		.clk(clk),
		.reset_n(reset_n),
		.carrierTick(carrierTick),
		.start(rxGuardStart),
		.unitShort(special_reg[`BIT_RX_UNIT]),
		.guardTime(rxGuardTime),
		.busy(rxGuardBusy),
		.done(rxGuardDone)
	);

	guard_timer #(.TIME_W(5)) txGuard (
		.clk(clk),
		.reset_n(reset_n),
		.carrierTick(carrierTick),
		.start(txGuardStart),
		.unitShort(special_reg[`BIT_TX_UNIT]),
		.guardTime(txGuardTime),
		.busy(txGuardBusy),
		.done(txGuardDone)
	);

	// ************************************************************
	// configuration outputs
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			demodCfg <= '0;
			driveCfg <= '0;
			fastRcTrim <= `RST_FTRIM;
			slowRcTrim <= 6'(`RST_STRIM);
			detectActive <= 1'h0;
			measureActive <= 1'h0;
		end else begin
			demodCfg.pskCharResync <= noise_reg[`BIT_RESYNC];
			demodCfg.topRateFilterBypass <= rxa6_reg[`BIT_FLT_BYP];
			demodCfg.subcarrierEndCheckOff <= rxa6_reg[`BIT_SUBEND];
			demodCfg.zeroHalfBitThreshold <= rxa8_reg[`FLD_ZERO_HALF];
			driveCfg.negEdgeStep <= edge_reg[`BIT_NEG_STEP];
			driveCfg.posEdgeStep <= edge_reg[`BIT_POS_STEP];
			driveCfg.negDriveConductance <= (state_reg != SEQ_IDLE) ?
				negDrv_reg[`FLD_NEG_DRV] : normNegDrive;
			driveCfg.posDriveConductance <= (state_reg != SEQ_IDLE) ?
				posCode_reg : normPosDrive;
			fastRcTrim <= fastTrim_reg;
			slowRcTrim <= slowTrim_reg[5:0];
			detectActive <= (state_reg != SEQ_IDLE);
			measureActive <= (state_reg == SEQ_DETECT);
		end
	end
endmodule

// ===== verification/lpcd_card_regs_assertions.sv
`timescale 1ns/10ps
module lpcd_card_regs_checker (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdata,
	input wire logic [3:0] normNegDrive,
	input wire logic [5:0] normPosDrive,
	input wire logic rxGuardStart,
	input wire logic [5:0] rxGuardTime,
	input wire logic rxGuardBusy,
	input wire logic rxGuardDone,
	input wire logic txGuardStart,
	input wire logic [4:0] txGuardTime,
	input wire logic txGuardBusy,
	input wire logic txGuardDone,
	input wire lpcd_pkg::demod_cfg_t demodCfg,
	input wire lpcd_pkg::drive_cfg_t driveCfg,
	input wire logic [7:0] fastRcTrim,
	input wire logic detectActive,
	input wire logic measureActive
);
	import lpcd_pkg::*;
	// ****
	// checks
	// ****
	logic [1:0] upCnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			upCnt <= 2'h0;
		end else if (upCnt != 2'h3) begin
			upCnt <= upCnt + 2'h1;
		end
	end
	sequence s_quiet;
		(!regWr && upCnt == 2'h3) [*2];
	endsequence
	sequence s_idle;
		(!detectActive && upCnt == 2'h3 && $stable(normNegDrive) && $stable(normPosDrive)) [*3];
	endsequence
	sequence s_rx_zero;
		rxGuardStart && rxGuardTime == 6'h00;
	endsequence
	a_read_idle_zero: assert property (!$past(regRd) |-> regRdata == 8'h00)
		else $error("read data outside read cycle");
	a_rx_zero_time: assert property (s_rx_zero |-> ##2 rxGuardDone)
		else $error("zero rx guard not done in 2 cycles");
	a_rx_busy_run: assert property (rxGuardStart && rxGuardTime != 6'h00 |=> rxGuardBusy [*8])
		else $error("rx guard not busy");
	a_tx_busy_run: assert property (txGuardStart && txGuardTime != 5'h00 |=> txGuardBusy [*8])
		else $error("tx guard not busy");
	a_rx_done_once: assert property (rxGuardDone |-> !rxGuardBusy ##1 !rxGuardDone)
		else $error("rx done not single pulse");
	a_tx_done_once: assert property (txGuardDone |-> !txGuardBusy ##1 !txGuardDone)
		else $error("tx done not single pulse");
	a_measure_in_mode: assert property (measureActive |-> detectActive)
		else $error("window outside detection mode");
	a_cfg_steady: assert property (s_quiet |=> $stable(demodCfg) && $stable(fastRcTrim)
		&& $stable({driveCfg.negEdgeStep, driveCfg.posEdgeStep})) else $error("config moved");
	a_normal_drive: assert property (s_idle |-> driveCfg.negDriveConductance == normNegDrive
		&& driveCfg.posDriveConductance == normPosDrive) else $error("normal drive not used");
endmodule
bind lpcd_card_regs lpcd_card_regs_checker lpcd_card_regs_checker_i (.clk, .reset_n, .regWr,
	.regRd, .regRdata, .normNegDrive, .normPosDrive, .rxGuardStart, .rxGuardTime, .rxGuardBusy,
	.rxGuardDone, .txGuardStart, .txGuardTime, .txGuardBusy, .txGuardDone, .demodCfg, .driveCfg,
	.fastRcTrim, .detectActive, .measureActive);

// ===== verification/testbench.sv
`timescale 1ns/10ps
module testbench;
	import lpcd_pkg::*;
	// ****
	// stimulus and checks
	// ****
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic rdSeen = 1'b0;
	logic rxGuardStart = 1'b0;
	logic txGuardStart = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic [7:0] adcSample = 8'h80;
	logic [3:0] normNegDrive = 4'h5;
	logic [5:0] normPosDrive = 6'h2A;
	logic [5:0] rxGuardTime = 6'h00;
	logic [4:0] txGuardTime = 5'h00;
	logic [7:0] regRdata, fastRcTrim;
	logic [5:0] slowRcTrim;
	logic rxGuardBusy, rxGuardDone, txGuardBusy, txGuardDone, detectActive, measureActive;
	logic tagDetectIrq;
	demod_cfg_t demodCfg;
	drive_cfg_t driveCfg;
	logic [7:0] expQ[$];
	logic [7:0] vals [20];
	logic [31:0] seed = 32'h00002829;
	int nErrors = 0;
	int testsRun = 0;
	int cycles = 0;
	localparam logic [31:0] TBL [20] = '{32'h5E3C003F, 32'h5E3D0FFF, 32'h5E3E04FF, 32'h5E3F50FF,
		32'hAE31143E, 32'hAE327DFF, 32'hAE33000C, 32'hAE34103F, 32'hAE3876FF, 32'hAE3956FF,
		32'hAE3A31FF, 32'hAE3B12FF, 32'h5A310000, 32'h5A320000, 32'h5A3300FF, 32'h5A3480FF,
		32'h5A35203F, 32'h5A3680FF, 32'h5A3830F0, 32'h5A391F3F};

	lpcd_card_regs lpcd_card_regs_i (.clk, .reset_n, .regAddr, .regWdata, .regWr, .regRd,
		.regRdata, .adcSample, .normNegDrive, .normPosDrive, .rxGuardStart, .rxGuardTime,
		.rxGuardBusy, .rxGuardDone, .txGuardStart, .txGuardTime, .txGuardBusy, .txGuardDone,
		.demodCfg, .driveCfg, .fastRcTrim, .slowRcTrim, .detectActive, .measureActive,
		.tagDetectIrq);

	function logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function logic [7:0] near(input int g, input int e);
		return 8'(g >= e - 5 && g <= e + 5);
	endfunction
	task check(input logic [7:0] seen, input logic [7:0] exp);
		testsRun++;
		if (seen !== exp) begin
			nErrors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task stopTest;
		if (nErrors == 0 && testsRun > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		expQ.push_back(e);
		@(posedge clk);
		regRd <= 1'b0;
	endtask
	task waitMeas(input logic v);
		for (int c = 0; c < 3000 && measureActive !== v; c++) begin
			@(posedge clk);
			#1;
		end
		check(8'(measureActive), 8'(v));
	endtask

	always #12.5 clk = ~clk;
	always @(posedge clk) rdSeen <= regRd;
	always @(negedge clk) if (rdSeen) check(regRdata, expQ.pop_front());
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			nErrors++;
			stopTest();
		end
	end

	initial begin
		int w, rxT, txT, nWin, winLen;
		logic [7:0] k, a, r, m, v;
		logic prev;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rd(8'h37, 8'h15);
		rd(8'h3D, 8'h00);
		foreach (TBL[i]) begin
			{k, a, r, m} = TBL[i];
			wr(8'h37, k);
			rd(a, r);
			v = rnd() & (a == 8'h3E ? 8'h7F : 8'hFF);
			wr(a, v);
			vals[i] = v & m;
			rd(a, vals[i]);
		end
		wr(8'h37, 8'hAE);
		wr(8'h3F, ~vals[3]);
		rd(8'h3C, 8'h00);
		wr(8'h37, 8'h5E);
		rd(8'h3F, vals[3]);
		wr(8'h37, 8'hAE);
		for (int j = 0; j < 2; j++) begin
			wr(8'h32, j ? 8'hEF : 8'h10);
			wr(8'h38, j ? 8'h77 : 8'h88);
			wr(8'h3A, j ? 8'h08 : 8'h1C);
			wr(8'h33, j ? 8'h04 : 8'h0C);
			repeat (2) @(posedge clk);
			#1;
			check(8'(demodCfg), j ? 8'h02 : 8'h3F);
			check(8'({driveCfg.negEdgeStep, driveCfg.posEdgeStep}), j ? 8'h01 : 8'h03);
		end
		wr(8'h37, 8'h5A);
		wr(8'h34, 8'hA5);
		wr(8'h35, 8'hFF);
		wr(8'h38, 8'hC0);
		wr(8'h39, 8'h2D);
		repeat (2) @(posedge clk);
		#1;
		check(fastRcTrim, 8'hA5);
		check(8'(slowRcTrim), 8'h3F);
		wr(8'h37, 8'h5E);
		for (int u = 0; u < 2; u++) begin
			wr(8'h3F, u ? 8'h53 : 8'h50);
			@(posedge clk);
			rxGuardStart <= 1'b1;
			rxGuardTime <= 6'h03;
			txGuardStart <= 1'b1;
			txGuardTime <= 5'h02;
			@(posedge clk);
			rxGuardStart <= 1'b0;
			txGuardStart <= 1'b0;
			rxT = 0;
			txT = 0;
			for (int c = 1; c < 3000 && (rxT == 0 || txT == 0); c++) begin
				@(posedge clk);
				#1;
				if (rxGuardDone === 1'b1) rxT = c;
				if (txGuardDone === 1'b1) txT = c;
			end
			w = u ? 64 : 128;
			check(near(rxT, 3 * w * 40000 / 13560), 8'h01);
			check(near(txT, 2 * w * 40000 / 13560), 8'h01);
		end
		@(posedge clk);
		rxGuardStart <= 1'b1;
		rxGuardTime <= 6'h00;
		@(posedge clk);
		rxGuardStart <= 1'b0;
		wr(8'h3C, 8'h05);
		wr(8'h3D, 8'h00);
		wr(8'h3E, 8'h91);
		nWin = 0;
		winLen = 0;
		prev = 1'b0;
		for (int c = 0; c < 3000 && tagDetectIrq !== 1'b1; c++) begin
			@(posedge clk);
			#1;
			if (measureActive === 1'b1 && !prev) nWin++;
			if (measureActive === 1'b1 && nWin == 1) winLen++;
			if (winLen == 10 && nWin == 1) begin
				check(8'(driveCfg.negDriveConductance), 8'h0C);
				check(8'(driveCfg.posDriveConductance), 8'h2D);
			end
			prev = measureActive;
		end
		check(8'(tagDetectIrq), 8'h01);
		check(8'(nWin), 8'h02);
		check(near(winLen, 64 * 40000 / 27120), 8'h01);
		wr(8'h37, 8'h5A);
		rd(8'h32, 8'h80);
		wr(8'h37, 8'h5E);
		wr(8'h3E, 8'h11);
		repeat (3) @(posedge clk);
		#1;
		check(8'(tagDetectIrq), 8'h00);
		check(8'(detectActive), 8'h00);
		wr(8'h3C, 8'h1F);
		wr(8'h37, 8'h5A);
		wr(8'h33, 8'h00);
		wr(8'h36, 8'h80);
		adcSample <= 8'h7B;
		wr(8'h37, 8'h5E);
		wr(8'h3E, 8'h81);
		repeat (2) begin
			waitMeas(1'b1);
			waitMeas(1'b0);
		end
		check(8'(tagDetectIrq), 8'h00);
		wr(8'h3E, 8'h01);
		wr(8'h37, 8'h5A);
		rd(8'h31, 8'h7B);
		rd(8'h32, 8'h7B);
		wr(8'h33, 8'h20);
		wr(8'h37, 8'h5E);
		wr(8'h3E, 8'h81);
		repeat (2) begin
			waitMeas(1'b1);
			waitMeas(1'b0);
		end
		waitMeas(1'b1);
		check(8'(driveCfg.posDriveConductance), 8'h34);
		repeat (2) @(posedge clk);
		stopTest();
	end
endmodule
